/* inc/dsc_pkg.sv */
// dsc_pkg: shared constants, register map and types for the decimation sync control block
package dsc_pkg;

  // ----------------------------------------------------------------
  // register map (internal address space, 10-bit)
  // ----------------------------------------------------------------
  localparam logic [9:0] ADDR_MODE = 10'h300;
  localparam logic [9:0] ADDR_OSC = 10'h301;
  localparam logic [9:0] ADDR_MASK = 10'h302;
  localparam logic [9:0] ADDR_TUNE = 10'h303;
  localparam logic [9:0] ADDR_PHOFF = 10'h304;
  localparam logic [9:0] ADDR_SCALE1 = 10'h305;
  localparam logic [9:0] ADDR_DEC1 = 10'h306;
  localparam logic [9:0] ADDR_SCALE2 = 10'h307;
  localparam logic [9:0] ADDR_DEC2 = 10'h308;
  localparam logic [9:0] ADDR_OUTSC = 10'h309;
  localparam logic [9:0] ADDR_DEC3 = 10'h30a;
  localparam logic [9:0] ADDR_COEF = 10'h30b;
  localparam logic [9:0] ADDR_TAPS = 10'h30c;
  localparam logic [9:0] ADDR_RSVD = 10'h30d;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_HOLD_BIT = 0;
  localparam int MODE_DIV_BIT = 1;
  localparam int MODE_CPLX_BIT = 2;
  localparam int MODE_MASTER_BIT = 3;
  localparam int OSC_BYPASS_BIT = 0;
  localparam int OSC_PDITH_BIT = 1;
  localparam int OSC_ADITH_BIT = 2;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam int SYNC_PINS = 3;
  localparam int UP_SYNC_W = 44;
  localparam int RESULT_W = 23;
  localparam int PORT_W = 16;
  localparam int PERIOD_W = 17;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [2:0] osc;
    logic [31:0] maskShadow;
    logic [31:0] tune;
    logic [15:0] phaseOff;
    logic [7:0] scale1;
    logic [7:0] dec1;
    logic [4:0] scale2;
    logic [7:0] dec2;
    logic [3:0] outScale;
    logic [7:0] dec3;
    logic [7:0] coefBase;
    logic [7:0] taps;
  } cfg_s;

  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_SER = 3'b010,
    ARB_UP = 3'b100
  } arb_e;

endpackage

/* rtl/dsc_decim_phase.sv */
// dsc_decim_phase: decimation phase counter of one filter stage
`timescale 1ns/100ps
`default_nettype none
module dsc_decim_phase #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hold,
  input wire logic advance,
  input wire logic syncHit,
  input wire logic [W-1:0] ratioM1,
  output logic [W-1:0] phase,
  output logic wrap
);

  logic [W-1:0] phase_ff, nxt_phase;
  logic wrap_ff, nxt_wrap;

  // ----------------------------------------------------------------
  // phase counting
  // ----------------------------------------------------------------
  // sync beats counting so a realign always lands exactly on phase zero
  always_comb begin
    nxt_phase = phase_ff;
    nxt_wrap = 1'b0;
    if (hold) begin
      nxt_phase = '0; // R25
    end else if (syncHit) begin
      // a sync landing on a natural wrap still passes the wrap on, or the next
      // stage would lose its advance and never wrap under a periodic master
      nxt_phase = '0; // R25 R7
      nxt_wrap = advance && (phase_ff == ratioM1);
    end else if (advance) begin
      if (phase_ff == ratioM1) begin
        nxt_phase = '0; // R21 R12
        nxt_wrap = 1'b1;
      end else begin
        nxt_phase = phase_ff + {{(W-1){1'b0}}, 1'b1}; // R4 R25
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      phase_ff <= '0;
      wrap_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      wrap_ff <= nxt_wrap;
    end
  end

  assign phase = phase_ff;
  assign wrap = wrap_ff;

  property p_syncZero;
    @(posedge sys_clk) disable iff (!rstn)
    syncHit |=> (phase_ff == '0) && wrap_ff == $past(advance && !hold && phase_ff == ratioM1);
  endproperty
  a_syncZero: assert property (p_syncZero) else $error("phase not zero after sync"); // R25

  property p_ratioWrap;
    @(posedge sys_clk) disable iff (!rstn)
    (advance && !hold && !syncHit && phase_ff == ratioM1) |=> wrap_ff && phase_ff == '0;
  endproperty
  a_ratioWrap: assert property (p_ratioWrap) else $error("stage did not wrap at ratio"); // R21

endmodule // dsc_decim_phase
`default_nettype wire

/* rtl/dsc_out_scale.sv */
// dsc_out_scale: rounding output scaler for the final filter result
`timescale 1ns/100ps
`default_nettype none
module dsc_out_scale (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [22:0] result,
  input wire logic resultValid,
  input wire logic [2:0] scale,
  input wire logic wideWord,
  output logic [23:0] portWord,
  output logic portValid
);

  logic signed [23:0] ext, rnd, sum, shr;
  logic [15:0] sat;
  logic [23:0] word_ff, nxt_word;
  logic valid_ff, nxt_valid;

  // ----------------------------------------------------------------
  // scale, round, saturate
  // ----------------------------------------------------------------
  // half an lsb of the kept field is added first, so the cut rounds
  always_comb begin
    ext = {result[22], result};
    rnd = (24'sh000001 <<< scale) >>> 1; // R2
    sum = ext + rnd;
    shr = sum >>> scale; // R1
    if (shr > 24'sh007fff) begin
      sat = 16'h7fff;
    end else if (shr < -24'sh008000) begin
      sat = 16'h8000;
    end else begin
      sat = shr[15:0];
    end
    nxt_valid = resultValid;
    nxt_word = word_ff;
    if (resultValid) begin
      nxt_word = wideWord ? ext : {{8{sat[15]}}, sat}; // R3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      word_ff <= 24'h0;
      valid_ff <= 1'b0;
    end else begin
      word_ff <= nxt_word;
      valid_ff <= nxt_valid;
    end
  end

  assign portWord = word_ff;
  assign portValid = valid_ff;

  property p_wideRaw;
    @(posedge sys_clk) disable iff (!rstn)
    (resultValid && wideWord) |=> portWord == {$past(result[22]), $past(result)};
  endproperty
  a_wideRaw: assert property (p_wideRaw) else $error("wide word was scaled"); // R3

endmodule // dsc_out_scale
`default_nettype wire

/* rtl/dsc_top.sv */
// dsc_top: register map, port arbitration and decimation sync for the receive channel
//
// Functional notes
// R1: output word is result times two^(7-scale); the scaler shifts the result right by scale instead
// R2: scaled result is rounded to 16 bits
// R3: 24/32-bit serial words bypass output scaling
// R4: each stage keeps its own decimation phase
// R5: master drives sync pulses on clock edge
// R6: slave samples sync pins as inputs
// R7: sync edge realigns comb and final stages
// R8: master comb pulse every m2 times m5 samples
// R9: final pulse every m3 comb pulses, coincident
// R10: pads driven as master, released as slave
// R11: master syncs from its own pad readback
// R12: stages free run without sync pulses
// R13: both control ports reach every register
// R14: serial wins unless micro cycle started
// R15: losing micro access waits, then proceeds
// R16: reset sets hold bit until cleared
// R17: reset clears master bit, slave at start
// R18: mode bits diversity, complex, master select
// R19: oscillator bits bypass, phase, amplitude dither
// R20: mask write loads shadow, read shows active
// R21: decimation register holds ratio minus one
// R22: final filter fetch starts at coefficient base
// R23: host writes zero to reserved locations
// R24: mode bits low means single real input
// R25: phase advances per sample, zero on sync
`timescale 1ns/100ps
`default_nettype none
module dsc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic serReq,
  input wire logic serWe,
  input wire logic [9:0] serAddr,
  input wire logic [31:0] serWdata,
  output logic serDone,
  output logic [31:0] serRdata,
  input wire logic upReq,
  input wire logic upWe,
  input wire logic [9:0] upAddr,
  input wire logic [31:0] upWdata,
  output logic upRdy,
  output logic [31:0] upRdata,
  input wire logic combSyncI,
  output logic combSyncO,
  output logic combSyncOen,
  input wire logic finalSyncI,
  output logic finalSyncO,
  output logic finalSyncOen,
  input wire logic oscSyncI,
  input wire logic sampleValid,
  input wire logic [22:0] filterResult,
  input wire logic resultValid,
  input wire logic wideWord,
  output logic [23:0] portWord,
  output logic portValid,
  output var dsc_pkg::cfg_s cfgOut,
  output logic [31:0] activeMask,
  output logic [3:0] modeFlags,
  output logic [7:0] cic2Phase,
  output logic [7:0] cic5Phase,
  output logic [7:0] finalPhase,
  output logic coefFetchStart,
  output logic [7:0] coefFetchAddr
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [dsc_pkg::UP_SYNC_W-1:0] upMeta_ff, upSync_ff;
  logic [dsc_pkg::SYNC_PINS-1:0] pinMeta_ff, pinSync_ff, pinLast_ff;
  logic upReqS, upWeS;
  logic [9:0] upAddrS;
  logic [31:0] upWdataS;
  logic combHit, finalHit, oscHit;

  // pad readback is used in both roles, so a master sees its own pulse
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      upMeta_ff <= '0;
      upSync_ff <= '0;
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      pinLast_ff <= '0;
    end else begin
      upMeta_ff <= {upReq, upWe, upAddr, upWdata};
      upSync_ff <= upMeta_ff;
      pinMeta_ff <= {oscSyncI, finalSyncI, combSyncI}; // R6 R11
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end

  // micro port lines are held steady for the whole cycle, so a bus sync is safe
  assign upReqS = upSync_ff[43];
  assign upWeS = upSync_ff[42];
  assign upAddrS = upSync_ff[41:32];
  assign upWdataS = upSync_ff[31:0];
  assign combHit = pinSync_ff[0] & ~pinLast_ff[0]; // R7 R11
  assign finalHit = pinSync_ff[1] & ~pinLast_ff[1]; // R7 R11
  assign oscHit = pinSync_ff[2] & ~pinLast_ff[2];

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] regRead(input dsc_pkg::cfg_s c, input logic [31:0] am,
                                          input logic [9:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      dsc_pkg::ADDR_MODE: r = {24'h0, c.mode};
      dsc_pkg::ADDR_OSC: r = {29'h0, c.osc};
      dsc_pkg::ADDR_MASK: r = am;
      dsc_pkg::ADDR_TUNE: r = c.tune;
      dsc_pkg::ADDR_PHOFF: r = {16'h0, c.phaseOff};
      dsc_pkg::ADDR_SCALE1: r = {24'h0, c.scale1};
      dsc_pkg::ADDR_DEC1: r = {24'h0, c.dec1};
      dsc_pkg::ADDR_SCALE2: r = {27'h0, c.scale2};
      dsc_pkg::ADDR_DEC2: r = {24'h0, c.dec2};
      dsc_pkg::ADDR_OUTSC: r = {28'h0, c.outScale};
      dsc_pkg::ADDR_DEC3: r = {24'h0, c.dec3};
      dsc_pkg::ADDR_COEF: r = {24'h0, c.coefBase};
      dsc_pkg::ADDR_TAPS: r = {24'h0, c.taps};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // port arbitration and register file
  // ----------------------------------------------------------------
  dsc_pkg::arb_e state_ff, nxt_state;
  dsc_pkg::cfg_s cfg_ff, nxt_cfg;
  logic [31:0] activeMask_ff, nxt_activeMask;
  logic [31:0] rdData_ff, nxt_rdData;
  logic serDone_ff, nxt_serDone;
  logic upServed_ff, nxt_upServed;
  logic [3:0] modeFlags_ff, nxt_modeFlags;
  logic upPend, accGo, accWe;
  logic [9:0] accAddr;
  logic [31:0] accWdata;

  // one access per grant; a micro cycle once granted cannot be pre-empted
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_activeMask = activeMask_ff;
    nxt_rdData = rdData_ff;
    nxt_serDone = 1'b0;
    nxt_upServed = upServed_ff & upReqS;
    upPend = upReqS & ~upServed_ff;
    accGo = 1'b0;
    accWe = 1'b0;
    accAddr = serAddr;
    accWdata = serWdata;
    case (state_ff)
      dsc_pkg::ARB_IDLE: begin
        if (serReq) begin
          nxt_state = dsc_pkg::ARB_SER; // R14
        end else if (upPend) begin
          nxt_state = dsc_pkg::ARB_UP; // R15
        end
      end
      dsc_pkg::ARB_SER: begin
        accGo = 1'b1;
        accWe = serWe; // R13
        nxt_serDone = 1'b1;
        nxt_state = dsc_pkg::ARB_IDLE;
      end
      dsc_pkg::ARB_UP: begin
        accGo = 1'b1;
        accWe = upWeS; // R13
        accAddr = upAddrS;
        accWdata = upWdataS;
        nxt_upServed = 1'b1;
        nxt_state = dsc_pkg::ARB_IDLE;
      end
      default: nxt_state = dsc_pkg::ARB_IDLE;
    endcase
    // the shadow mask takes effect on an oscillator sync edge
    if (oscHit) begin
      nxt_activeMask = cfg_ff.maskShadow; // R20
    end
    if (accGo) begin
      nxt_rdData = regRead(cfg_ff, activeMask_ff, accAddr); // R20
    end
    // reserved locations and bits are expected to be written as zero
    if (accGo && accWe) begin
      case (accAddr)
        dsc_pkg::ADDR_MODE: nxt_cfg.mode = accWdata[7:0]; // R16 R18 R23
        dsc_pkg::ADDR_OSC: nxt_cfg.osc = accWdata[2:0]; // R19
        dsc_pkg::ADDR_MASK: nxt_cfg.maskShadow = accWdata; // R20
        dsc_pkg::ADDR_TUNE: nxt_cfg.tune = accWdata;
        dsc_pkg::ADDR_PHOFF: nxt_cfg.phaseOff = accWdata[15:0];
        dsc_pkg::ADDR_SCALE1: nxt_cfg.scale1 = accWdata[7:0];
        dsc_pkg::ADDR_DEC1: nxt_cfg.dec1 = accWdata[7:0]; // R21
        dsc_pkg::ADDR_SCALE2: nxt_cfg.scale2 = accWdata[4:0];
        dsc_pkg::ADDR_DEC2: nxt_cfg.dec2 = accWdata[7:0]; // R21
        dsc_pkg::ADDR_OUTSC: nxt_cfg.outScale = accWdata[3:0];
        dsc_pkg::ADDR_DEC3: nxt_cfg.dec3 = accWdata[7:0]; // R21
        dsc_pkg::ADDR_COEF: nxt_cfg.coefBase = accWdata[7:0]; // R22
        dsc_pkg::ADDR_TAPS: nxt_cfg.taps = accWdata[7:0];
        default: nxt_cfg = cfg_ff;
      endcase
    end
    // flags: single real, diversity, complex, master
    nxt_modeFlags[0] = ~|cfg_ff.mode[2:0]; // R24
    nxt_modeFlags[1] = cfg_ff.mode[dsc_pkg::MODE_DIV_BIT]; // R18
    nxt_modeFlags[2] = cfg_ff.mode[dsc_pkg::MODE_CPLX_BIT]; // R18
    nxt_modeFlags[3] = cfg_ff.mode[dsc_pkg::MODE_MASTER_BIT]; // R18
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff <= dsc_pkg::ARB_IDLE;
      cfg_ff <= '0;
      cfg_ff.mode <= dsc_pkg::MODE_RESET; // R16 R17
      activeMask_ff <= 32'h0;
      rdData_ff <= 32'h0;
      serDone_ff <= 1'b0;
      upServed_ff <= 1'b0;
      modeFlags_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      activeMask_ff <= nxt_activeMask;
      rdData_ff <= nxt_rdData;
      serDone_ff <= nxt_serDone;
      upServed_ff <= nxt_upServed;
      modeFlags_ff <= nxt_modeFlags;
    end
  end

  // ----------------------------------------------------------------
  // master pulse generator
  // ----------------------------------------------------------------
  logic hold, master;
  logic [dsc_pkg::PERIOD_W-1:0] period, genCnt_ff, nxt_genCnt;
  logic [7:0] genFin_ff, nxt_genFin;
  logic combOut_ff, nxt_combOut, finalOut_ff, nxt_finalOut, oen_ff, nxt_oen;

  assign hold = cfg_ff.mode[dsc_pkg::MODE_HOLD_BIT];
  assign master = cfg_ff.mode[dsc_pkg::MODE_MASTER_BIT];
  assign period = dsc_pkg::PERIOD_W'((18'(cfg_ff.dec1) + 18'h1) * (18'(cfg_ff.dec2) + 18'h1));

  // kept apart from the stage counters: those realign from the pad, and a
  // generator reset by its own echo would stretch every period by the latency
  always_comb begin
    nxt_genCnt = genCnt_ff;
    nxt_genFin = genFin_ff;
    nxt_combOut = 1'b0;
    nxt_finalOut = 1'b0;
    nxt_oen = ~master; // R10
    if (hold || !master) begin
      nxt_genCnt = '0;
      nxt_genFin = 8'h0;
    end else if (sampleValid) begin
      if (genCnt_ff == period - 17'h1) begin
        nxt_genCnt = '0;
        nxt_combOut = 1'b1; // R5 R8
        if (genFin_ff == cfg_ff.dec3) begin
          nxt_genFin = 8'h0;
          nxt_finalOut = 1'b1; // R9
        end else begin
          nxt_genFin = genFin_ff + 8'h1;
        end
      end else begin
        nxt_genCnt = genCnt_ff + 17'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      genCnt_ff <= '0;
      genFin_ff <= 8'h0;
      combOut_ff <= 1'b0;
      finalOut_ff <= 1'b0;
      oen_ff <= 1'b1;
    end else begin
      genCnt_ff <= nxt_genCnt;
      genFin_ff <= nxt_genFin;
      combOut_ff <= nxt_combOut;
      finalOut_ff <= nxt_finalOut;
      oen_ff <= nxt_oen;
    end
  end

  // ----------------------------------------------------------------
  // stage phase counters and output scaler
  // ----------------------------------------------------------------
  logic wrap2, wrap5, wrap3;
  logic fetch_ff, nxt_fetch;
  logic [7:0] fetchAddr_ff, nxt_fetchAddr;

  dsc_decim_phase #(.W(8)) u_cic2 (
    .sys_clk(sys_clk), .rstn(rstn), .hold(hold), .advance(sampleValid),
    .syncHit(combHit), .ratioM1(cfg_ff.dec1), .phase(cic2Phase), .wrap(wrap2)
  ); // R4 R12

  dsc_decim_phase #(.W(8)) u_cic5 (
    .sys_clk(sys_clk), .rstn(rstn), .hold(hold), .advance(wrap2),
    .syncHit(combHit), .ratioM1(cfg_ff.dec2), .phase(cic5Phase), .wrap(wrap5)
  ); // R4 R12

  dsc_decim_phase #(.W(8)) u_final (
    .sys_clk(sys_clk), .rstn(rstn), .hold(hold), .advance(wrap5),
    .syncHit(finalHit), .ratioM1(cfg_ff.dec3), .phase(finalPhase), .wrap(wrap3)
  ); // R4 R12

  // each final wrap launches one filter computation from the base address
  always_comb begin
    nxt_fetch = wrap3;
    nxt_fetchAddr = wrap3 ? cfg_ff.coefBase : fetchAddr_ff; // R22
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fetch_ff <= 1'b0;
      fetchAddr_ff <= 8'h0;
    end else begin
      fetch_ff <= nxt_fetch;
      fetchAddr_ff <= nxt_fetchAddr;
    end
  end

  dsc_out_scale u_scale (
    .sys_clk(sys_clk), .rstn(rstn), .result(filterResult), .resultValid(resultValid),
    .scale(cfg_ff.outScale[2:0]), .wideWord(wideWord), .portWord(portWord),
    .portValid(portValid)
  ); // R1 R2 R3

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign serDone = serDone_ff;
  assign serRdata = rdData_ff;
  assign upRdy = upServed_ff;
  assign upRdata = rdData_ff;
  assign combSyncO = combOut_ff;
  assign combSyncOen = oen_ff;
  assign finalSyncO = finalOut_ff;
  assign finalSyncOen = oen_ff;
  assign cfgOut = cfg_ff;
  assign activeMask = activeMask_ff;
  assign modeFlags = modeFlags_ff;
  assign coefFetchStart = fetch_ff;
  assign coefFetchAddr = fetchAddr_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_serWins;
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff == dsc_pkg::ARB_IDLE && serReq) |=> state_ff == dsc_pkg::ARB_SER;
  endproperty
  a_serWins: assert property (p_serWins) else $error("serial did not win"); // R14

  property p_upAfterSer;
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff == dsc_pkg::ARB_IDLE && serReq && upPend)
      |=> (state_ff == dsc_pkg::ARB_SER && !upRdy) ##1 (state_ff == dsc_pkg::ARB_IDLE && !upRdy)
      ##1 (state_ff == dsc_pkg::ARB_UP && !upRdy) ##1 upRdy;
  endproperty
  a_upAfterSer: assert property (p_upAfterSer) else $error("micro access not resumed"); // R15

  property p_resetMode;
    @(posedge sys_clk) $rose(rstn) |-> cfg_ff.mode == dsc_pkg::MODE_RESET && oen_ff;
  endproperty
  a_resetMode: assert property (p_resetMode) else $error("mode wrong after reset"); // R16 R17

  property p_drive;
    @(posedge sys_clk) disable iff (!rstn)
    master |=> !combSyncOen && !finalSyncOen;
  endproperty
  a_drive: assert property (p_drive) else $error("master not driving pads"); // R10

  property p_coincide;
    @(posedge sys_clk) disable iff (!rstn)
    finalSyncO |-> combSyncO && !combSyncOen;
  endproperty
  a_coincide: assert property (p_coincide) else $error("final pulse without comb pulse"); // R9

  property p_period;
    @(posedge sys_clk) disable iff (!rstn)
    (master && !hold && sampleValid && genCnt_ff == period - 17'h1) |=> combSyncO;
  endproperty
  a_period: assert property (p_period) else $error("comb pulse missed"); // R8

  property p_shadow;
    @(posedge sys_clk) disable iff (!rstn)
    (accGo && accWe && accAddr == dsc_pkg::ADDR_MASK && !oscHit)
      |=> activeMask_ff == $past(activeMask_ff) && cfg_ff.maskShadow == $past(accWdata);
  endproperty
  a_shadow: assert property (p_shadow) else $error("mask write reached active mask"); // R20

  property p_serWrite;
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff == dsc_pkg::ARB_SER && serWe && serAddr == dsc_pkg::ADDR_DEC1)
      |=> cfg_ff.dec1 == $past(serWdata[7:0]) && serDone;
  endproperty
  a_serWrite: assert property (p_serWrite) else $error("serial write lost"); // R13

endmodule // dsc_top
`default_nettype wire

/* tb/dsc_sync_peer.sv */
// dsc_sync_peer: peer receiver acting as sync master on the shared pads
`timescale 1ns/100ps
`default_nettype none
module dsc_sync_peer (
  input wire logic sys_clk,
  input wire logic fire,
  output logic combDrv,
  output logic finalDrv,
  output logic oscDrv
);
  // one-cycle pulse on all three pads per fire request, launched just after the edge;
  // released pads fall to the board pull-down, never a held last value
  always @(posedge sys_clk) begin
    combDrv <= #2 fire;
    finalDrv <= #2 fire;
    oscDrv <= #2 fire;
  end
endmodule // dsc_sync_peer
`default_nettype wire

/* tb/dsc_top_test.sv */
// dsc_top_test: self-checking bench for register access, sync and output scaling
`timescale 1ns/100ps
`default_nettype none
module dsc_top_test;
  logic sys_clk = 0, rstn = 0, serReq = 0, serWe = 0, upReq = 0, upWe = 0, fire = 0;
  logic sampleValid = 0, resultValid = 0, wideWord = 0;
  logic [9:0] serAddr = 0, upAddr = 0;
  logic [31:0] serWdata = 0, upWdata = 0, serRdata, upRdata, activeMask, v;
  logic [22:0] filterResult = 0;
  logic serDone, upRdy, combSyncO, combSyncOen, finalSyncO, finalSyncOen, portValid;
  logic coefFetchStart, combDrv, finalDrv, oscDrv;
  logic [23:0] portWord;
  logic [3:0] modeFlags;
  logic [7:0] cic2Phase, cic5Phase, finalPhase, coefFetchAddr;
  dsc_pkg::cfg_s cfgOut;
  int miscompares = 0, cmpCount = 0, seed = 22314, n, nc, nf, nx, nd;
  logic [31:0] rdQ[$];
  logic [31:0] upQ[$];
  logic upLast = 0;
  logic [23:0] pwQ[$];
  // pads: own driver when enabled (active low) ORed with the peer, else pull-down
  wire combPad = (~combSyncOen & combSyncO) | combDrv;
  wire finalPad = (~finalSyncOen & finalSyncO) | finalDrv;

  always #12.5 sys_clk = ~sys_clk;

  dsc_top u_dsc_top (.sys_clk, .rstn, .serReq, .serWe, .serAddr, .serWdata, .serDone,
    .serRdata, .upReq, .upWe, .upAddr, .upWdata, .upRdy, .upRdata, .combSyncI(combPad),
    .combSyncO, .combSyncOen, .finalSyncI(finalPad), .finalSyncO, .finalSyncOen,
    .oscSyncI(oscDrv), .sampleValid, .filterResult, .resultValid, .wideWord, .portWord,
    .portValid, .cfgOut, .activeMask, .modeFlags, .cic2Phase, .cic5Phase, .finalPhase,
    .coefFetchStart, .coefFetchAddr);
  dsc_sync_peer u_dsc_sync_peer (.sys_clk, .fire, .combDrv, .finalDrv, .oscDrv);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares=%0d mismatches=%0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tmo;
    miscompares++;
    conclude;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  // serial access; a read notes its expected word for the monitor
  task automatic ser(input logic we, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    serWe = we;
    serAddr = a;
    serWdata = d;
    serReq = 1;
    if (!we) rdQ.push_back(e);
    for (int i = 0; i < 20 && serDone !== 1'b1; i++) cyc(1);
    if (serDone !== 1'b1) tmo;
    serReq = 0;
    cyc(1);
  endtask

  // micro access: hold until ready, then wait for ready to fall; a read notes its word
  task automatic upa(input logic we, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    upWe = we;
    upAddr = a;
    upWdata = d;
    upReq = 1;
    if (!we) upQ.push_back(e);
    for (int i = 0; i < 30 && upRdy !== 1'b1; i++) cyc(1);
    if (upRdy !== 1'b1) tmo;
    upReq = 0;
    for (int i = 0; i < 30 && upRdy !== 1'b0; i++) cyc(1);
    if (upRdy !== 1'b0) tmo;
  endtask

  task automatic res(input logic w, input logic [22:0] r, input logic [23:0] e);
    wideWord = w;
    filterResult = r;
    resultValid = 1;
    pwQ.push_back(e);
    cyc(1);
    resultValid = 0;
    cyc(1);
  endtask

  // monitor: sample just after each edge, once registered outputs have landed
  always @(posedge sys_clk) begin
    #1;
    if (serDone === 1'b1 && serWe === 1'b0) chk(serRdata, rdQ.pop_front());
    if (portValid === 1'b1) chk({8'h0, portWord}, {8'h0, pwQ.pop_front()});
    if (upRdy === 1'b1 && upLast === 1'b0 && upWe === 1'b0) chk(upRdata, upQ.pop_front());
    upLast = upRdy;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(2);
    rstn = 1;
    cyc(1);
    ser(0, dsc_pkg::ADDR_MODE, 0, 32'h1);
    ser(0, dsc_pkg::ADDR_RSVD, 0, 32'h0);
    ser(0, 10'h3ff, 0, 32'h0);
    v = $random(seed);
    v = v & 32'h7;
    upa(1, dsc_pkg::ADDR_DEC1, v, 0);
    ser(0, dsc_pkg::ADDR_DEC1, 0, v);
    // micro read meets a serial write: serial goes first, micro then reads its value
    fork
      upa(0, dsc_pkg::ADDR_DEC1, 0, 32'h3);
      begin
        cyc(2);
        ser(1, dsc_pkg::ADDR_DEC1, 32'h3, 0);
      end
    join
    ser(1, dsc_pkg::ADDR_OUTSC, 32'h7, 0);
    res(0, 23'h000080, 24'h000001);
    res(0, 23'h0000c0, 24'h000002);
    res(1, 23'h400000, 24'hc00000);
    // slave: odd ratios so a free-running all-zero phase is rare
    ser(1, dsc_pkg::ADDR_DEC1, 32'h2, 0);
    ser(1, dsc_pkg::ADDR_DEC2, 32'h4, 0);
    ser(1, dsc_pkg::ADDR_DEC3, 32'h6, 0);
    ser(1, dsc_pkg::ADDR_MASK, 32'h5a, 0);
    ser(0, dsc_pkg::ADDR_MASK, 0, 32'h0);
    ser(1, dsc_pkg::ADDR_MODE, 32'h0, 0);
    sampleValid = 1;
    cyc(10);
    chk(modeFlags, 32'h1);
    fire = 1;
    cyc(1);
    fire = 0;
    for (n = 0; n < 10 && {cic2Phase, cic5Phase, finalPhase} !== 24'h0; n++) cyc(1);
    chk({cic2Phase, cic5Phase, finalPhase}, 32'h0);
    cyc(1);
    chk(cic2Phase, 32'h1);
    chk(combSyncOen, 32'h1);
    ser(0, dsc_pkg::ADDR_MASK, 0, 32'h5a);
    chk(activeMask, 32'h5a);
    v = $random(seed) & 32'hff;
    ser(1, dsc_pkg::ADDR_COEF, v, 0);
    chk(cfgOut.coefBase, v);
    // master at full rate: comb every 4 cycles, final every 12
    ser(1, dsc_pkg::ADDR_DEC1, 32'h1, 0);
    ser(1, dsc_pkg::ADDR_DEC2, 32'h1, 0);
    ser(1, dsc_pkg::ADDR_DEC3, 32'h2, 0);
    ser(1, dsc_pkg::ADDR_MODE, 32'h8, 0);
    cyc(20);
    chk(modeFlags, 32'h9);
    nd = 0;
    nc = 0;
    nf = 0;
    nx = 0;
    for (int i = 0; i < 48; i++) begin
      if (combSyncO === 1'b1) nc++;
      if (finalSyncO === 1'b1) nf++;
      if (finalSyncO === 1'b1 && combSyncO !== 1'b1) nx++;
      if (coefFetchStart === 1'b1) nd++;
      cyc(1);
    end
    chk(nc, 12);
    chk(nf, 4);
    chk(nx, 0);
    chk(nd, 4);
    chk(coefFetchAddr, v);
    chk(combSyncOen, 32'h0);
    conclude;
  end
endmodule // dsc_top_test
`default_nettype wire
